// ---- common/tam_pkg.sv ----
// Package: shared constants of the two-axis motion setup block
// Assumes a 40 MHz clock and a 32-bit APB register bus
package tam_pkg;
  // Register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_PERIOD = 12'h004;
  localparam logic [11:0] OFF_ACCEL = 12'h008;
  localparam logic [11:0] OFF_LOW = 12'h00c;
  localparam logic [11:0] OFF_HIGH = 12'h010;
  localparam logic [11:0] OFF_AXIS = 12'h014;
  localparam logic [11:0] OFF_STATUS = 12'h018;
  localparam logic [11:0] OFF_MOVE = 12'h01c;
  localparam logic [11:0] OFF_ID = 12'h020;
  // Slot base addresses
  localparam logic [9:0] SLOT_LO_BASE = 10'h080;
  localparam logic [9:0] SLOT_HI_BASE = 10'h140;
  localparam logic [9:0] SLOT_STEP = 10'h020;
  localparam int SLOT_GROUP = 4;
  localparam logic [4:0] CARD_MAX = 5'h13;
  // Field positions of the axis register
  localparam int AX_XDIR = 0;
  localparam int AX_YDIR = 1;
  localparam int AX_XFMT = 2;
  localparam int AX_YFMT = 3;
  localparam int AX_XHOLD = 4;
  localparam int AX_YHOLD = 5;
  localparam int AX_POL = 6;
  // Control register bits
  localparam int CTRL_RESET_ALL = 0;
  // Move register fields
  localparam int MV_XGO = 0;
  localparam int MV_YGO = 1;
  localparam int MV_XDIR = 2;
  localparam int MV_YDIR = 3;
  localparam int MV_HOME = 4;
  // Reset values
  localparam logic [7:0] PERIOD_RST = 8'h0a;
  localparam logic [7:0] ACCEL_RST = 8'h01;
  localparam logic [7:0] LOW_RST = 8'h0a;
  localparam logic [10:0] HIGH_RST = 11'h064;
  localparam logic [7:0] PERIOD_MIN = 8'h01;
  localparam logic [7:0] PERIOD_MAX = 8'hfe;
  // Identity value, arbitrary
  localparam logic [31:0] CARD_ID = 32'h00005a01;
  // Time unit 1.024 ms
  localparam int CLK_HZ = 40000000;
  localparam int UNIT_NS = 1024000;
  localparam int UNIT_CYC = UNIT_NS / (1000000000 / CLK_HZ);
endpackage : tam_pkg

// ---- verilog/tam_sync.sv ----
// Two-flop synchroniser bank for switch pins
// Assumes pins are asynchronous to clk
`timescale 1ns/1ps
module tam_sync #(
  parameter int W = 7
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      // Open-contact idle level, so no switch looks active after reset
      s1_r <= '1;
      q <= '1;
    end
    else
    begin
      s1_r <= d;
      q <= s1_r;
    end
  end
endmodule : tam_sync

// ---- verilog/tam_axis.sv ----
// One axis pulse generator: speed pulses per interpolation period
// Assumes period tick from the top and synchronised active switches
`timescale 1ns/1ps
module tam_axis (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clear,
  input wire logic tick,
  input wire logic go,
  input wire logic dir_cmd,
  input wire logic home_mode,
  input wire logic [10:0] speed,
  input wire logic dir_invert,
  input wire logic dual_pulse_format,
  input wire logic home_act,
  input wire logic left_act,
  input wire logic right_act,
  input wire logic emg_act,
  output logic pulse_a,
  output logic pulse_b,
  output logic busy
);
  logic busy_r;
  logic dir_r;
  logic [10:0] left_r;
  logic [15:0] gap_r;
  logic pulse_r;
  logic out_dir;
  logic stop_req;
  // Backward motion is toward the left switch
  assign stop_req = emg_act | (home_mode & home_act) | (dir_r ? left_act : right_act);
  // Inversion applied at the output only
  assign out_dir = dir_r ^ dir_invert;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_r <= 1'b0;
      dir_r <= 1'b0;
      left_r <= '0;
      gap_r <= '0;
      pulse_r <= 1'b0;
    end
    else if (clear || (busy_r && stop_req))
    begin
      busy_r <= 1'b0;
      left_r <= '0;
      pulse_r <= 1'b0;
    end
    else
    begin
      if (go && !busy_r)
      begin
        busy_r <= 1'b1;
        dir_r <= dir_cmd;
      end
      pulse_r <= 1'b0;
      if (busy_r && tick)
      begin
        left_r <= speed;
        gap_r <= '0;
      end
      else if (busy_r && left_r != 11'h000)
      begin
        gap_r <= gap_r + 16'h0001;
        if (gap_r[4:0] == 5'h1f)
        begin
          pulse_r <= 1'b1;
          left_r <= left_r - 11'h001;
        end
      end
    end
  end
  assign pulse_a = dual_pulse_format ? (pulse_r & ~out_dir) : pulse_r;
  assign pulse_b = dual_pulse_format ? (pulse_r & out_dir) : out_dir;
  assign busy = busy_r;
endmodule : tam_axis

// ---- verilog/tam_top.sv ----
// Two-axis pulse motion card setup logic with APB register access
// Assumes APB master on clk; switch pins asynchronous; drivers take pulse outputs
//
// Functional notes
// - Binding answers only when the selected address belongs to this card and the card number is at most 13h, else the bind flags failure.
// - The card decodes its slot base from the slot number: 80h-E0h for slots 0-3, 140h-1A0h for 4-7.
// - Reset-all aborts running motion and restores every setting default.
// - Period setting 1 to 254 gives a period of setting plus one times 1.024 ms.
// - Speed is pulses per period; acceleration is the speed step per period.
// - Defaults are period 10, acceleration 1, low speed 10, high speed 100.
// - Each axis has a direction invert bit applied at the output.
// - Forward moves away from the motor, backward toward it, after inversion.
// - Each axis selects dual pulse lines or pulse plus direction.
// - Each axis drives its own hold enable output from its setting.
// - One polarity bit sets all home, limit and emergency inputs active low or high.
// - Limit protection judges switches through the selected polarity.
// - Home stop is seen at period ticks, so its delay grows with the period.
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module tam_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] slot_number,
  input wire logic [9:0] bind_address,
  input wire logic [4:0] bind_card,
  input wire logic bind_req,
  output logic bind_ok,
  output logic bind_fail,
  input wire logic x_home_switch,
  input wire logic y_home_switch,
  input wire logic x_left_limit_switch,
  input wire logic x_right_limit_switch,
  input wire logic y_left_limit_switch,
  input wire logic y_right_limit_switch,
  input wire logic emergency_switch,
  output logic x_pulse_a,
  output logic x_pulse_b,
  output logic y_pulse_a,
  output logic y_pulse_b,
  output logic x_hold_enable,
  output logic y_hold_enable,
  output logic x_stop,
  output logic y_stop
);
  ////////////////////////////////////////////////////////////////////////////
  // Slot address decode and binding
  function automatic logic [9:0] slot_base(input logic [2:0] s);
    logic [9:0] b;
    b = (s < 3'(tam_pkg::SLOT_GROUP)) ? tam_pkg::SLOT_LO_BASE : tam_pkg::SLOT_HI_BASE;
    slot_base = b + 10'(s[1:0]) * tam_pkg::SLOT_STEP;
  endfunction : slot_base

  logic [9:0] my_base;
  logic addr_hit;
  logic bind_ok_r;
  logic bind_fail_r;
  logic [4:0] card_r;
  assign my_base = slot_base(slot_number);
  assign addr_hit = (bind_address == my_base) && (bind_card <= tam_pkg::CARD_MAX);
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bind_ok_r <= 1'b0;
      bind_fail_r <= 1'b0;
      card_r <= '0;
    end
    else
    begin
      bind_ok_r <= bind_req & addr_hit;
      bind_fail_r <= bind_req & ~addr_hit;
      if (bind_req && addr_hit)
      begin
        card_r <= bind_card;
      end
    end
  end
  assign bind_ok = bind_ok_r;
  assign bind_fail = bind_fail_r;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  logic wr_en;
  logic rd_en;
  logic sel_ctrl, sel_period, sel_accel, sel_low, sel_high, sel_axis, sel_status, sel_move, sel_id;
  logic mapped;
  logic reset_all;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign sel_ctrl = paddr == tam_pkg::OFF_CTRL;
  assign sel_period = paddr == tam_pkg::OFF_PERIOD;
  assign sel_accel = paddr == tam_pkg::OFF_ACCEL;
  assign sel_low = paddr == tam_pkg::OFF_LOW;
  assign sel_high = paddr == tam_pkg::OFF_HIGH;
  assign sel_axis = paddr == tam_pkg::OFF_AXIS;
  assign sel_status = paddr == tam_pkg::OFF_STATUS;
  assign sel_move = paddr == tam_pkg::OFF_MOVE;
  assign sel_id = paddr == tam_pkg::OFF_ID;
  assign mapped = sel_ctrl | sel_period | sel_accel | sel_low | sel_high | sel_axis | sel_status
    | sel_move | sel_id;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign reset_all = wr_en & sel_ctrl & pwdata[tam_pkg::CTRL_RESET_ALL];

  ////////////////////////////////////////////////////////////////////////////
  // Settings
  logic [7:0] period_r;
  logic [7:0] accel_r;
  logic [7:0] low_r;
  logic [10:0] high_r;
  logic [6:0] axis_r;
  logic period_ok;
  assign period_ok = (pwdata[7:0] >= tam_pkg::PERIOD_MIN) && (pwdata[7:0] <= tam_pkg::PERIOD_MAX);
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      period_r <= tam_pkg::PERIOD_RST;
      accel_r <= tam_pkg::ACCEL_RST;
      low_r <= tam_pkg::LOW_RST;
      high_r <= tam_pkg::HIGH_RST;
      axis_r <= '0;
    end
    else if (reset_all)
    begin
      period_r <= tam_pkg::PERIOD_RST;
      accel_r <= tam_pkg::ACCEL_RST;
      low_r <= tam_pkg::LOW_RST;
      high_r <= tam_pkg::HIGH_RST;
      axis_r <= '0;
    end
    else if (wr_en)
    begin
      // Writes to a register leave the others unchanged
      if (sel_period && period_ok)
      begin
        period_r <= pwdata[7:0];
      end
      if (sel_accel)
      begin
        accel_r <= pwdata[7:0];
      end
      if (sel_low)
      begin
        low_r <= pwdata[7:0];
      end
      if (sel_high)
      begin
        high_r <= pwdata[10:0];
      end
      if (sel_axis)
      begin
        axis_r <= pwdata[6:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interpolation period timer: (setting+1) time units
  logic [15:0] unit_cnt_r;
  logic [7:0] per_cnt_r;
  logic unit_tick;
  logic per_tick;
  assign unit_tick = unit_cnt_r == 16'(tam_pkg::UNIT_CYC - 1);
  assign per_tick = unit_tick && (per_cnt_r >= period_r);
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      unit_cnt_r <= '0;
      per_cnt_r <= '0;
    end
    else if (reset_all)
    begin
      unit_cnt_r <= '0;
      per_cnt_r <= '0;
    end
    else
    begin
      unit_cnt_r <= unit_tick ? 16'h0000 : unit_cnt_r + 16'h0001;
      if (unit_tick)
      begin
        per_cnt_r <= (per_cnt_r >= period_r) ? 8'h00 : per_cnt_r + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch inputs with polarity
  logic [6:0] sw_raw;
  logic [6:0] sw_sync;
  logic [6:0] sw_act;
  logic [6:0] sw_held_r;
  logic switch_polarity_select;
  assign sw_raw = {emergency_switch, y_right_limit_switch, y_left_limit_switch, y_home_switch,
    x_right_limit_switch, x_left_limit_switch, x_home_switch};
  tam_sync #(.W(7)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d(sw_raw),
    .q(sw_sync)
  );
  assign switch_polarity_select = axis_r[tam_pkg::AX_POL];
  // Open contacts are active low, closed contacts active high
  assign sw_act = switch_polarity_select ? sw_sync : ~sw_sync;
  // Home switch sampled only at period ticks
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sw_held_r <= '0;
    end
    else if (per_tick)
    begin
      sw_held_r <= sw_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Motion and speed ramp
  logic [10:0] x_speed_r;
  logic [10:0] y_speed_r;
  logic x_busy, y_busy;
  logic [4:0] move_r;
  logic go_x, go_y;
  logic [10:0] ramp_top;
  assign go_x = wr_en & sel_move & pwdata[tam_pkg::MV_XGO];
  assign go_y = wr_en & sel_move & pwdata[tam_pkg::MV_YGO];
  assign ramp_top = high_r;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      move_r <= '0;
      x_speed_r <= '0;
      y_speed_r <= '0;
    end
    else if (reset_all)
    begin
      move_r <= '0;
      x_speed_r <= '0;
      y_speed_r <= '0;
    end
    else
    begin
      if (wr_en && sel_move)
      begin
        move_r <= pwdata[4:0];
      end
      // Start at low speed, step by acceleration each period
      if (!x_busy)
      begin
        x_speed_r <= 11'(low_r);
      end
      else if (per_tick && x_speed_r < ramp_top)
      begin
        x_speed_r <= (12'(x_speed_r) + 12'(accel_r) > 12'(ramp_top)) ? ramp_top : x_speed_r + 11'(accel_r);
      end
      if (!y_busy)
      begin
        y_speed_r <= 11'(low_r);
      end
      else if (per_tick && y_speed_r < ramp_top)
      begin
        y_speed_r <= (12'(y_speed_r) + 12'(accel_r) > 12'(ramp_top)) ? ramp_top : y_speed_r + 11'(accel_r);
      end
    end
  end

  tam_axis u_x (
    .clk(clk),
    .rstn(rstn),
    .clear(reset_all),
    .tick(per_tick),
    .go(go_x),
    .dir_cmd(pwdata[tam_pkg::MV_XDIR]),
    .home_mode(move_r[tam_pkg::MV_HOME]),
    .speed(x_speed_r),
    .dir_invert(axis_r[tam_pkg::AX_XDIR]),
    .dual_pulse_format(~axis_r[tam_pkg::AX_XFMT]),
    .home_act(sw_held_r[0]),
    .left_act(sw_act[1]),
    .right_act(sw_act[2]),
    .emg_act(sw_act[6]),
    .pulse_a(x_pulse_a),
    .pulse_b(x_pulse_b),
    .busy(x_busy)
  );
  tam_axis u_y (
    .clk(clk),
    .rstn(rstn),
    .clear(reset_all),
    .tick(per_tick),
    .go(go_y),
    .dir_cmd(pwdata[tam_pkg::MV_YDIR]),
    .home_mode(move_r[tam_pkg::MV_HOME]),
    .speed(y_speed_r),
    .dir_invert(axis_r[tam_pkg::AX_YDIR]),
    .dual_pulse_format(~axis_r[tam_pkg::AX_YFMT]),
    .home_act(sw_held_r[3]),
    .left_act(sw_act[4]),
    .right_act(sw_act[5]),
    .emg_act(sw_act[6]),
    .pulse_a(y_pulse_a),
    .pulse_b(y_pulse_b),
    .busy(y_busy)
  );
  assign x_hold_enable = axis_r[tam_pkg::AX_XHOLD];
  assign y_hold_enable = axis_r[tam_pkg::AX_YHOLD];
  assign x_stop = ~x_busy;
  assign y_stop = ~y_busy;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [31:0] rd_val;
  assign rd_val = sel_period ? {24'h000000, period_r}
    : sel_accel ? {24'h000000, accel_r}
    : sel_low ? {24'h000000, low_r}
    : sel_high ? {21'h000000, high_r}
    : sel_axis ? {25'h0000000, axis_r}
    : sel_status ? {16'h0000, card_r, sw_act, 2'b00, y_busy, x_busy}
    : sel_move ? {27'h0000000, move_r}
    : sel_id ? tam_pkg::CARD_ID
    : 32'h00000000;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata <= '0;
    end
    else if (psel && !penable && !pwrite)
    begin
      prdata <= rd_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_reset_defaults: assert property (@(posedge clk) disable iff (!rstn)
    reset_all |=> (period_r == tam_pkg::PERIOD_RST && high_r == tam_pkg::HIGH_RST && axis_r == 7'h00))
    else $error("reset-all did not restore defaults");
  a_abort_motion: assert property (@(posedge clk) disable iff (!rstn)
    reset_all |=> !x_busy && !y_busy)
    else $error("motion not aborted");
  a_period_range: assert property (@(posedge clk) disable iff (!rstn)
    period_r >= tam_pkg::PERIOD_MIN && period_r <= tam_pkg::PERIOD_MAX)
    else $error("period out of range");
  a_hold_follow: assert property (@(posedge clk) disable iff (!rstn)
    (wr_en && sel_axis) |=> x_hold_enable == $past(pwdata[tam_pkg::AX_XHOLD])
    && y_hold_enable == $past(pwdata[tam_pkg::AX_YHOLD]))
    else $error("hold enable mismatch");
  a_polarity_use: assert property (@(posedge clk) disable iff (!rstn)
    sw_act == (switch_polarity_select ? sw_sync : ~sw_sync))
    else $error("switch polarity wrong");
  a_bind_answer: assert property (@(posedge clk) disable iff (!rstn)
    bind_req |=> (bind_ok ^ bind_fail))
    else $error("bind gave no single answer");
  a_emg_stop: assert property (@(posedge clk) disable iff (!rstn)
    (x_busy && sw_act[6]) |=> !x_busy)
    else $error("emergency did not stop");
  a_hold_setting: assert property (@(posedge clk) disable iff (!rstn)
    !(wr_en && (sel_ctrl || sel_axis)) |=> $stable(axis_r))
    else $error("settings changed unwritten");
endmodule : tam_top

// ---- tb/tam_motor_model.sv ----
// Model of the motor drivers and the limit switches
// Assumes the bench sets switch activity and the polarity in use
`timescale 1ns/1ps
module tam_motor_model (
  input wire logic clk,
  input wire logic clr,
  input wire logic x_pulse_a,
  input wire logic x_pulse_b,
  input wire logic y_pulse_a,
  input wire logic pol,
  input wire logic [6:0] act,
  output logic [6:0] pins,
  output int xa_cnt,
  output int xb_cnt,
  output int ya_cnt
);
  logic [2:0] last_r;
  // Contacts idle at the inactive level of the chosen polarity
  assign pins = pol ? act : ~act;
  ////////////////////////////////////////////////////////////
  // Rising edges counted on x_pulse_a, x_pulse_b and y_pulse_a
  always @(posedge clk)
  begin
    last_r <= {x_pulse_a, x_pulse_b, y_pulse_a};
    if (clr)
    begin
      xa_cnt <= 0;
      xb_cnt <= 0;
      ya_cnt <= 0;
    end
    else
    begin
      if (x_pulse_a && !last_r[2]) xa_cnt <= xa_cnt + 1;
      if (x_pulse_b && !last_r[1]) xb_cnt <= xb_cnt + 1;
      if (y_pulse_a && !last_r[0]) ya_cnt <= ya_cnt + 1;
    end
  end
endmodule : tam_motor_model

// ---- tb/tam_top_tb.sv ----
// Self-checking bench of the two-axis motion setup block
// Assumes the motor model is compiled first; card slot strap driven by the bench
`timescale 1ns/1ps
module tam_top_tb;
  localparam int LIMIT = 100000;
  logic clk, rstn, psel, penable, pwrite, bind_req, clr, pol;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er, bind_ok, bind_fail;
  logic [9:0] bind_address;
  logic [4:0] bind_card;
  logic [2:0] slot;
  logic [6:0] act, pins;
  logic xa, xb, ya, yb, xh, yh, xs, ys;
  int xa_cnt, xb_cnt, ya_cnt;
  int mismatches, compares, cycles;
  tam_top dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slot_number(slot), .bind_address(bind_address), .bind_card(bind_card),
    .bind_req(bind_req), .bind_ok(bind_ok), .bind_fail(bind_fail),
    .x_home_switch(pins[0]), .x_left_limit_switch(pins[1]), .x_right_limit_switch(pins[2]),
    .y_home_switch(pins[3]), .y_left_limit_switch(pins[4]), .y_right_limit_switch(pins[5]),
    .emergency_switch(pins[6]), .x_pulse_a(xa), .x_pulse_b(xb), .y_pulse_a(ya),
    .y_pulse_b(yb), .x_hold_enable(xh), .y_hold_enable(yh), .x_stop(xs), .y_stop(ys));
  tam_motor_model model (.clk(clk), .clr(clr), .x_pulse_a(xa), .x_pulse_b(xb),
    .y_pulse_a(ya), .pol(pol), .act(act), .pins(pins), .xa_cnt(xa_cnt),
    .xb_cnt(xb_cnt), .ya_cnt(ya_cnt));
  ////////////////////////////////////////////////////////////
  task print_verdict;
    if (mismatches == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task bind_try(input logic [9:0] a, input logic [4:0] c, input logic ok);
    @(posedge clk);
    bind_req <= 1'b1;
    bind_address <= a;
    bind_card <= c;
    @(posedge clk);
    bind_req <= 1'b0;
    @(negedge clk);
    chk("bind ok", {31'h0, ok}, {31'h0, bind_ok});
    chk("bind fail", {31'h0, !ok}, {31'h0, bind_fail});
  endtask : bind_try
  ////////////////////////////////////////////////////////////
  task t_defaults;
    apb(0, tam_pkg::OFF_PERIOD, 0);
    chk("period", 32'h0000000a, rd);
    apb(0, tam_pkg::OFF_ACCEL, 0);
    chk("accel", 32'h00000001, rd);
    apb(0, tam_pkg::OFF_LOW, 0);
    chk("low", 32'h0000000a, rd);
    apb(0, tam_pkg::OFF_HIGH, 0);
    chk("high", 32'h00000064, rd);
    chk("holds", 32'h0, {30'h0, xh, yh});
    chk("ready", 32'h00000001, {31'h0, pready});
    apb(0, 12'h024, 0);
    chk("unmapped", 32'h80000000, {er, rd[30:0]});
  endtask : t_defaults
  task automatic t_period;
    logic [7:0] wv[4] = '{8'h00, 8'hff, 8'hfe, 8'h01};
    logic [7:0] ev[4] = '{8'h0a, 8'h0a, 8'hfe, 8'h01};
    for (int i = 0; i < 4; i++)
    begin
      apb(1, tam_pkg::OFF_PERIOD, {24'h0, wv[i]});
      apb(0, tam_pkg::OFF_PERIOD, 0);
      chk("period range", {24'h0, ev[i]}, rd);
    end
  endtask : t_period
  task t_speeds;
    apb(1, tam_pkg::OFF_ACCEL, 32'h000000c8);
    apb(1, tam_pkg::OFF_LOW, 32'h000000c8);
    apb(1, tam_pkg::OFF_HIGH, 32'h000007ff);
    apb(1, tam_pkg::OFF_AXIS, 32'h00000010);
    @(negedge clk);
    chk("holds", 32'h00000002, {30'h0, xh, yh});
    apb(1, tam_pkg::OFF_AXIS, 32'h00000020);
    @(negedge clk);
    chk("holds", 32'h00000001, {30'h0, xh, yh});
    apb(0, tam_pkg::OFF_ACCEL, 0);
    chk("accel", 32'h000000c8, rd);
    apb(0, tam_pkg::OFF_LOW, 0);
    chk("low", 32'h000000c8, rd);
    apb(0, tam_pkg::OFF_HIGH, 0);
    chk("high", 32'h000007ff, rd);
  endtask : t_speeds
  task automatic t_bind;
    logic [9:0] base[8] = '{10'h080, 10'h0a0, 10'h0c0, 10'h0e0, 10'h140, 10'h160, 10'h180, 10'h1a0};
    for (int s = 0; s < 8; s++)
    begin
      @(posedge clk);
      slot <= 3'(s);
      for (int i = 0; i < 8; i++)
        bind_try(base[i], 5'h13, i == s);
    end
    bind_try(10'h1a0, 5'h14, 1'b0);
    apb(0, tam_pkg::OFF_STATUS, 0);
    chk("card", 32'h00000013, {27'h0, rd[15:11]});
  endtask : t_bind
  task t_switch;
    for (int p = 0; p < 2; p++)
    begin
      apb(1, tam_pkg::OFF_AXIS, p << 6);
      pol <= p[0];
      act <= 7'h55;
      repeat (4) @(posedge clk);
      apb(0, tam_pkg::OFF_STATUS, 0);
      chk("switches", 32'h00000055, {25'h0, rd[10:4]});
    end
    act <= 7'h04;
    apb(1, tam_pkg::OFF_MOVE, 32'h00000001);
    repeat (10) @(posedge clk);
    chk("x stop at limit", 32'h1, {31'h0, xs});
    act <= 7'h40;
    apb(1, tam_pkg::OFF_MOVE, 32'h00000002);
    repeat (10) @(posedge clk);
    chk("y stop at emergency", 32'h1, {31'h0, ys});
    act <= 7'h00;
  endtask : t_switch
  task t_move;
    int n;
    pol <= 1'b0;
    apb(1, tam_pkg::OFF_AXIS, 32'h0000000a);
    apb(1, tam_pkg::OFF_PERIOD, 32'h00000001);
    clr <= 1'b0;
    apb(1, tam_pkg::OFF_MOVE, 32'h00000003);
    n = 0;
    while (xa_cnt == 0 && n < 90000)
    begin
      @(posedge clk);
      n++;
    end
    chk("x cw pulses", 32'h1, {31'h0, xa_cnt > 0});
    chk("y pulses", 32'h1, {31'h0, ya_cnt > 0});
    chk("x ccw pulses", 32'h0, xb_cnt);
    chk("y dir level", 32'h1, {31'h0, yb});
    chk("x stop moving", 32'h0, {31'h0, xs});
    apb(1, tam_pkg::OFF_CTRL, 32'h00000001);
    repeat (3) @(posedge clk);
    chk("stops", 32'h3, {30'h0, xs, ys});
    apb(0, tam_pkg::OFF_PERIOD, 0);
    chk("period", 32'h0000000a, rd);
    apb(0, tam_pkg::OFF_AXIS, 0);
    chk("axis", 32'h0, rd);
  endtask : t_move
  ////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      mismatches++;
      print_verdict();
    end
  end
  initial
  begin
    {rstn, psel, penable, pwrite, bind_req, pol} = 6'h0;
    {paddr, pwdata, bind_address, bind_card, act, slot} = '0;
    clr = 1'b1;
    mismatches = 0;
    compares = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_defaults();
    t_period();
    t_speeds();
    t_bind();
    t_switch();
    t_move();
    print_verdict();
  end
endmodule : tam_top_tb
